/* design/tfr_pkg.sv */
// constants and types shared by the trace packet encoder
`default_nettype none
package tfr_pkg;
  localparam logic [7:0] HDR_EXC     = 8'h06;
  localparam logic [7:0] HDR_CC_UNK  = 8'h0F;
  localparam logic [7:0] EXC_TAIL    = 8'h70;
  localparam logic [4:0] FAIL_MID    = 5'h18;
  localparam logic [4:0] RST_MID     = 5'h00;
  localparam logic [1:0] SEL_ONLY    = 2'h1;
  localparam logic [1:0] SEL_TGT     = 2'h2;
  localparam int         SEL_HI_POS  = 6;
  localparam int         SEL_LO_POS  = 0;
  localparam int         MID_POS     = 1;
  localparam int         CONT_POS    = 7;
  localparam int         GROUP_BITS  = 7;
  localparam int         EXC_LEN     = 3;
  localparam int         FIFO_DEPTH  = 32;
  localparam logic [2:0] LEN_RESET   = 3'h0;
  localparam logic [47:0] PKT_RESET  = 48'h0;

  typedef enum logic [1:0] {
    KIND_FAIL  = 2'b00,
    KIND_RESET = 2'b01,
    KIND_CYCLE = 2'b10
  } tfr_kind_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EMIT = 1'b1
  } tfr_state_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tfr_byte_t;

  typedef struct packed {
    tfr_state_t  st;
    logic [47:0] pkt;
    logic [2:0]  len;
    logic        refused;
  } tfr_enc_t;
endpackage
`default_nettype wire

/* design/tfr_encoder.sv */
// trace packet encoder: failure, reset and unknown-count cycle packets
`timescale 1ns/100ps
`default_nettype none

module tfr_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } tfr_fptr_t;

  tfr_fptr_t   ptr_ff;
  tfr_fptr_t   nxt_ptr;
  logic [W-1:0] mem_ff [D];
  logic        full;
  logic        empty;

  assign full        = (ptr_ff.wr[AW] != ptr_ff.rd[AW]) &&
                       (ptr_ff.wr[AW-1:0] == ptr_ff.rd[AW-1:0]);
  assign empty       = ptr_ff.wr == ptr_ff.rd;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[ptr_ff.rd[AW-1:0]];

  always_comb begin
    nxt_ptr = ptr_ff;
    if (in_valid_i && !full) begin
      nxt_ptr.wr = ptr_ff.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      nxt_ptr.rd = ptr_ff.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // storage needs no reset; only pointers decide what is valid
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_ff[ptr_ff.wr[AW-1:0]] <= in_data_i;
    end
  end

  property p_no_push_full;
    @(posedge clk_i) disable iff (reset_i)
    full |-> !in_ready_o ##1 (ptr_ff.wr == $past(ptr_ff.wr));
  endproperty
  a_no_push_full: assert property (p_no_push_full)
    else $error("fifo accepted a word while full");
endmodule

module tfr_encoder (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [1:0]  req_kind_i,
  input  wire logic        req_tgt_unknown_i,
  input  wire logic [31:0] req_commit_i,
  input  wire logic        commit_option_flag_i,
  input  wire logic        cycle_count_support_flag_i,
  output logic             req_refused_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [7:0]       out_data_o,
  output logic             out_last_o
);
  tfr_pkg::tfr_enc_t  enc_ff;
  tfr_pkg::tfr_enc_t  nxt_enc;
  tfr_pkg::tfr_byte_t push_byte;
  tfr_pkg::tfr_byte_t pop_byte;
  logic               fifo_ready;
  logic               push;
  logic               accept;
  logic               cyc_ok;

  // number of base-128 groups in the shortest form of the count
  function automatic logic [2:0] le128_len(input logic [31:0] v);
    if (v[31:28] != 4'h0) begin
      return 3'h5;
    end else if (v[27:21] != 7'h00) begin
      return 3'h4;
    end else if (v[20:14] != 7'h00) begin
      return 3'h3;
    end else if (v[13:7] != 7'h00) begin
      return 3'h2;
    end
    return 3'h1;
  endfunction

  function automatic logic [47:0] exc_pkt(input logic [4:0] mid, input logic tgt);
    logic [1:0] sel;
    logic [7:0] b1;
    sel = tgt ? tfr_pkg::SEL_TGT : tfr_pkg::SEL_ONLY;
    b1 = 8'h00;
    b1[tfr_pkg::SEL_HI_POS] = sel[1];
    b1[tfr_pkg::SEL_LO_POS] = sel[0];
    b1[tfr_pkg::MID_POS +: 5] = mid;
    return {24'h000000, tfr_pkg::EXC_TAIL, b1, tfr_pkg::HDR_EXC};
  endfunction

  function automatic logic [47:0] cyc_pkt(input logic [31:0] v);
    logic [47:0] p;
    logic [2:0]  n;
    n = le128_len(v);
    p = tfr_pkg::PKT_RESET;
    p[7:0] = tfr_pkg::HDR_CC_UNK;
    for (int i = 0; i < 4; i++) begin
      p[8*(i+1) + tfr_pkg::CONT_POS] = n > 3'(i + 1);
      p[8*(i+1) +: tfr_pkg::GROUP_BITS] = v[tfr_pkg::GROUP_BITS*i +: tfr_pkg::GROUP_BITS];
    end
    p[47:40] = {4'h0, v[31:28]};
    return p;
  endfunction

  assign req_ready_o = enc_ff.st == tfr_pkg::ST_IDLE;
  assign accept      = req_valid_i && req_ready_o;
  assign cyc_ok      = !commit_option_flag_i && cycle_count_support_flag_i;
  assign push        = (enc_ff.st == tfr_pkg::ST_EMIT) && fifo_ready;
  assign push_byte   = '{last: enc_ff.len == 3'h1, data: enc_ff.pkt[7:0]};

  always_comb begin
    nxt_enc = enc_ff;
    nxt_enc.refused = 1'b0;
    case (enc_ff.st)
      tfr_pkg::ST_IDLE: begin
        if (accept) begin
          if (req_kind_i == tfr_pkg::KIND_FAIL) begin
            nxt_enc.pkt = exc_pkt(tfr_pkg::FAIL_MID, req_tgt_unknown_i);
            nxt_enc.len = 3'(tfr_pkg::EXC_LEN);
            nxt_enc.st  = tfr_pkg::ST_EMIT;
          end else if (req_kind_i == tfr_pkg::KIND_RESET) begin
            nxt_enc.pkt = exc_pkt(tfr_pkg::RST_MID, req_tgt_unknown_i);
            nxt_enc.len = 3'(tfr_pkg::EXC_LEN);
            nxt_enc.st  = tfr_pkg::ST_EMIT;
          end else if (req_kind_i == tfr_pkg::KIND_CYCLE && cyc_ok) begin
            // zero count is a single zero byte
            nxt_enc.pkt = cyc_pkt(req_commit_i);
            nxt_enc.len = le128_len(req_commit_i) + 3'h1;
            nxt_enc.st  = tfr_pkg::ST_EMIT;
          end else begin
            nxt_enc.refused = 1'b1;
          end
        end
      end
      tfr_pkg::ST_EMIT: begin
        // new requests wait until the last byte is queued
        if (push) begin
          nxt_enc.pkt = {8'h00, enc_ff.pkt[47:8]};
          nxt_enc.len = enc_ff.len - 3'h1;
          if (enc_ff.len == 3'h1) begin
            nxt_enc.st = tfr_pkg::ST_IDLE;
          end
        end
      end
      default: nxt_enc.st = tfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enc_ff <= '{st: tfr_pkg::ST_IDLE, pkt: tfr_pkg::PKT_RESET,
                  len: tfr_pkg::LEN_RESET, refused: 1'b0};
    end else begin
      enc_ff <= nxt_enc;
    end
  end

  assign req_refused_o = enc_ff.refused;

  // buffer absorbs sink stalls; a full buffer holds the encoder in place
  tfr_fifo #(
    .W($bits(tfr_pkg::tfr_byte_t)),
    .D(tfr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .in_valid_i (enc_ff.st == tfr_pkg::ST_EMIT),
    .in_ready_o (fifo_ready),
    .in_data_i  (push_byte),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o (pop_byte)
  );

  assign out_data_o = pop_byte.data;
  assign out_last_o = pop_byte.last;

  // position and header of the byte being queued, for the checks below
  logic [2:0] pos_ff;
  logic [7:0] hdr_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pos_ff <= 3'h0;
      hdr_ff <= 8'h00;
    end else if (push) begin
      pos_ff <= push_byte.last ? 3'h0 : pos_ff + 3'h1;
      if (pos_ff == 3'h0) begin
        hdr_ff <= push_byte.data;
      end
    end
  end

  property p_fail_pkt;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i == tfr_pkg::KIND_FAIL |=>
      enc_ff.len == 3'h3 && enc_ff.pkt[13:9] == 5'h18 && enc_ff.pkt[23:16] == 8'h70;
  endproperty
  a_fail_pkt: assert property (p_fail_pkt)
    else $error("failure packet layout wrong");

  property p_sel_tgt;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i != tfr_pkg::KIND_CYCLE && req_kind_i[1] == 1'b0 |=>
      {enc_ff.pkt[14], enc_ff.pkt[8]} == ($past(req_tgt_unknown_i) ? 2'b10 : 2'b01);
  endproperty
  a_sel_tgt: assert property (p_sel_tgt)
    else $error("selector does not match target request");

  property p_sel_legal;
    @(posedge clk_i) disable iff (reset_i)
    push && pos_ff == 3'h1 && hdr_ff == 8'h06 |->
      push_byte.data[6] != push_byte.data[0];
  endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("reserved selector emitted");

  property p_rst_pkt;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i == tfr_pkg::KIND_RESET |=>
      enc_ff.len == 3'h3 && enc_ff.pkt[13:9] == 5'h00 && enc_ff.pkt[7:0] == 8'h06;
  endproperty
  a_rst_pkt: assert property (p_rst_pkt)
    else $error("reset packet layout wrong");

  property p_gate;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i == tfr_pkg::KIND_CYCLE &&
      (commit_option_flag_i || !cycle_count_support_flag_i) |=>
      req_refused_o && enc_ff.st == tfr_pkg::ST_IDLE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("cycle packet not gated by configuration");

  property p_hdr;
    @(posedge clk_i) disable iff (reset_i)
    push && pos_ff == 3'h0 |-> push_byte.data inside {8'h06, 8'h0F};
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("packet does not start with a header");

  property p_cont;
    @(posedge clk_i) disable iff (reset_i)
    push && hdr_ff == 8'h0F && pos_ff != 3'h0 |->
      (pos_ff == 3'h5) ? (push_byte.data[7:4] == 4'h0 && push_byte.last)
                       : (push_byte.data[7] == !push_byte.last);
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuation flag wrong");

  property p_zero;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i == tfr_pkg::KIND_CYCLE && cyc_ok && req_commit_i == 32'h0 |=>
      enc_ff.len == 3'h2 && enc_ff.pkt[15:8] == 8'h00;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero commit count not a single zero byte");

  property p_short;
    @(posedge clk_i) disable iff (reset_i)
    accept && req_kind_i == tfr_pkg::KIND_CYCLE && cyc_ok &&
      req_commit_i[31:7] == 25'h0 |=> enc_ff.len == 3'h2;
  endproperty
  a_short: assert property (p_short)
    else $error("commit count not in shortest form");

  property p_contig;
    @(posedge clk_i) disable iff (reset_i)
    push && !push_byte.last |-> !req_ready_o ##1 enc_ff.st == tfr_pkg::ST_EMIT;
  endproperty
  a_contig: assert property (p_contig)
    else $error("packet interrupted before last byte");
endmodule

`default_nettype wire

/* tb/tfr_sink.sv */
// trace byte sink model with commit field decoder
`timescale 1ns/100ps
`default_nettype none

module tfr_sink (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  output logic            ready_o
);
  logic [8:0]  got[$];
  logic [31:0] dec;
  logic        first;
  logic        in_cm;
  logic        has_cm;
  logic        phase;
  int          sh;

  initial begin
    ready_o = 1'b0;
    phase = 1'b0;
  end

  // mode 0 prompt, 1 every other cycle, 2 stalled
  always @(negedge clk_i) begin
    phase <= ~phase;
    ready_o <= !reset_i && (mode_i == 2'h0 || (mode_i == 2'h1 && phase));
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      first = 1'b1;
      in_cm = 1'b0;
    end else if (valid_i && ready_o) begin
      got.push_back({last_i, data_i});
      if (in_cm) begin
        dec = dec | (32'(data_i[6:0]) << sh);
        sh = sh + 7;
        in_cm = data_i[7];
        has_cm = !data_i[7] && dec != 32'h0;
      end else if (first && data_i == 8'h0F) begin
        in_cm = 1'b1;
        dec = 32'h0;
        sh = 0;
        has_cm = 1'b0;
      end
      first = last_i;
    end
  end
endmodule

`default_nettype wire

/* tb/tfr_encoder_tb_top.sv */
// self-checking testbench for the trace packet encoder
`timescale 1ns/100ps
`default_nettype none

module tfr_encoder_tb_top;
  logic        clk_i;
  logic        reset_i;
  logic        req_valid_i;
  logic        tgt;
  logic        opt;
  logic        cc;
  logic        rdy;
  logic        ref_o;
  logic        req_ready_o;
  logic        out_valid_o;
  logic        out_last_o;
  logic [7:0]  out_data_o;
  logic [1:0]  kind;
  logic [1:0]  mode;
  logic [31:0] cm;
  logic [8:0]  exp_q[$];
  logic [31:0] tbl[7] = '{32'h0, 32'h7F, 32'h80, 32'hC8, 32'h0FFFFFFF, 32'h10000000,
                          32'hFFFFFFFF};
  int          fails;
  int          check_count;
  int          cyc;

  tfr_encoder dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_kind_i(kind), .req_tgt_unknown_i(tgt),
    .req_commit_i(cm), .commit_option_flag_i(opt), .cycle_count_support_flag_i(cc),
    .req_refused_o(ref_o), .out_valid_o(out_valid_o), .out_ready_i(rdy),
    .out_data_o(out_data_o), .out_last_o(out_last_o));

  tfr_sink u_sink (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode), .valid_i(out_valid_o),
    .data_i(out_data_o), .last_i(out_last_o), .ready_o(rdy));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk9(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected byte at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected flag at %0t: got %b want %b", $time, g, e);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic l);
    exp_q.push_back({l, b});
  endtask

  task automatic setm(input logic [1:0] m);
    @(posedge clk_i);
    mode = m;
  endtask

  // hold the request until the edge that takes it, then look at the refusal pulse
  task automatic send(input logic [1:0] k, input logic t, input logic [31:0] c,
                      input logic o, input logic s, input logic er);
    int n;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    kind = k;
    tgt = t;
    cm = c;
    opt = o;
    cc = s;
    n = 0;
    // ready comes from the state register, so it is settled at the falling edge
    while (req_ready_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk1(req_ready_o, 1'b1);
    @(posedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    chk1(ref_o, er);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (u_sink.got.size() < exp_q.size() && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
    chk1(u_sink.got.size() == exp_q.size(), 1'b1);
    foreach (exp_q[i])
      if (i < u_sink.got.size()) chk9(u_sink.got[i], exp_q[i]);
    exp_q.delete();
    u_sink.got.delete();
  endtask

  // all four failure and reset variants back to back
  task automatic t_exc();
    logic [1:0] sel;
    for (int k = 0; k < 4; k++) begin
      sel = k[0] ? 2'h2 : 2'h1;
      send({1'b0, k[1]}, k[0], 32'h0, 1'b0, 1'b1, 1'b0);
      put(8'h06, 1'b0);
      put({1'b0, sel[1], k[1] ? 5'h00 : 5'h18, sel[0]}, 1'b0);
      put(8'h70, 1'b1);
    end
    drain();
  endtask

  // commit boundaries through a slow sink
  task automatic t_cyc();
    logic [31:0] v;
    logic        more;
    setm(2'h1);
    foreach (tbl[i]) begin
      send(2'h2, 1'b0, tbl[i], 1'b0, 1'b1, 1'b0);
      put(8'h0F, 1'b0);
      v = tbl[i];
      do begin
        more = (v >> 7) != 32'h0;
        put({more, v[6:0]}, !more);
        v = v >> 7;
      end while (more);
      drain();
      chk9(u_sink.dec[8:0], tbl[i][8:0]);
      chk1(u_sink.dec == tbl[i], 1'b1);
      chk1(u_sink.has_cm, tbl[i] != 32'h0);
    end
    setm(2'h0);
  endtask

  task automatic t_ref();
    send(2'h3, 1'b0, 32'h5, 1'b0, 1'b1, 1'b1);
    send(2'h2, 1'b0, 32'h5, 1'b1, 1'b1, 1'b1);
    send(2'h2, 1'b0, 32'h5, 1'b0, 1'b0, 1'b1);
    drain();
  endtask

  // stalled sink: 33 bytes do not fit, encoder must wait
  task automatic t_fill();
    setm(2'h2);
    repeat (11) begin
      send(2'h0, 1'b0, 32'h0, 1'b0, 1'b1, 1'b0);
      put(8'h06, 1'b0);
      put(8'h31, 1'b0);
      put(8'h70, 1'b1);
    end
    repeat (6) @(negedge clk_i);
    chk1(req_ready_o, 1'b0);
    chk1(out_valid_o, 1'b1);
    setm(2'h0);
    drain();
    @(negedge clk_i);
    chk1(out_valid_o, 1'b0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    {reset_i, req_valid_i, tgt, opt, cc, kind, mode, cm} = '0;
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    chk1(req_ready_o, 1'b1);
    chk1(out_valid_o, 1'b0);
    t_exc();
    t_cyc();
    t_ref();
    t_fill();
    stop_test();
  end
endmodule

`default_nettype wire
